// ==== pkg/meas_nvm_pkg.sv ====
// constants and types shared by the measurement result and nvm control bank
package meas_nvm_pkg;

   // ==========================================================
   // register indices on the register port
   localparam logic [7:0] ADDR_CORR_IN_VOLT = 8'h31;
   localparam logic [7:0] ADDR_CORR_OUT_VOLT = 8'h32;
   localparam logic [7:0] ADDR_CORR_OUT_CURR = 8'h33;
   localparam logic [7:0] ADDR_NVM_CTRL = 8'h34;

   // ==========================================================
   // field layout
   localparam int CODE_W = 12;
   localparam int WORD_W = 16;
   localparam int CODE_LSB = 4;      // code sits in bits 15..4
   localparam int SAVE_BIT = 0;
   localparam int RESTORE_BIT = 1;
   localparam int NUM_RESULTS = 3;

   // measurement slot numbers on the result update port
   localparam logic [1:0] SLOT_IN_VOLT = 2'h0;
   localparam logic [1:0] SLOT_OUT_VOLT = 2'h1;
   localparam logic [1:0] SLOT_OUT_CURR = 2'h2;

   // sampling select encodings
   localparam logic [1:0] SEL_IN_VOLT = 2'h0;
   localparam logic [1:0] SEL_OUT_VOLT = 2'h1;
   localparam logic [1:0] SEL_OUT_CURR_MIRROR = 2'h2;
   localparam logic [1:0] SEL_OUT_CURR = 2'h3;

   // scaling, for reference by software models
   localparam int VOLT_CODES_PER_VOLT = 100;
   localparam int CURR_CODE_OFFSET = 1024;
   localparam int CURR_UV_PER_CODE = 25;

   // ==========================================================
   // values after reset
   localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] NVM_CTRL_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] READ_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      NVM_IDLE = 2'b00,
      NVM_SAVE = 2'b01,
      NVM_RESTORE = 2'b10
   } nvm_state_type;

endpackage

// ==== logic/meas_nvm_bank.sv ====
// measurement result words and nvm save/restore control register bank
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Input voltage code bits 11..0 read in word bits 15..4.
// - Bits 3..0 of every result word read as zero.
// - Input voltage code over 100 gives volts, stored unaltered.
// - Output voltage code sits in bits 15..4, code over 100 is volts.
// - Output current code bits 11..0 read in word bits 15..4.
// - Output current code is offset binary around 1024, unaltered.
// - Result words are read only and host writes have no effect.
// - A one in nvm control bit 1 with bit 0 clear starts a restore, cleared when done.
// - A one in nvm control bit 0 starts a save, cleared when done.
// - Nvm control bits 15..2 read zero and requests reset to zero.
// - With automatic sampling a read of the chosen word triggers, except for the mirror select, which matches only reads of 8'hff.
module meas_nvm_bank
   import meas_nvm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [WORD_W-1:0] reg_wdata,
   output logic [WORD_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // results from the conversion engine
   input wire logic meas_valid,
   input wire logic [1:0] meas_slot,
   input wire logic [CODE_W-1:0] meas_code,
   // sampling configuration from the adc start register
   input wire logic auto_sample,
   input wire logic [1:0] sampling_select,
   output logic conv_trigger,
   // nvm engine handshake
   output logic save_start,
   output logic restore_start,
   input wire logic nvm_done
);

   // ==========================================================
   // helpers
   // pack a 12-bit code into the upper bits of a word, low nibble zero
   function automatic logic [WORD_W-1:0] pack_code(
      input logic [CODE_W-1:0] code
   );
      pack_code = {code, 4'h0};
   endfunction

   // address of the word chosen by the sampling select field
   function automatic logic [7:0] sel_addr(input logic [1:0] sel);
      case (sel)
         SEL_IN_VOLT: sel_addr = ADDR_CORR_IN_VOLT;
         SEL_OUT_VOLT: sel_addr = ADDR_CORR_OUT_VOLT;
         SEL_OUT_CURR: sel_addr = ADDR_CORR_OUT_CURR;
         default: sel_addr = 8'hff; // mirror word lives outside this bank
      endcase
   endfunction

   // ==========================================================
   // result storage
   logic [CODE_W-1:0] result_r [NUM_RESULTS];
   logic [CODE_W-1:0] result_nxt [NUM_RESULTS];

   // whole code replaced at once; host writes never reach here
   always_comb begin
      for (int i = 0; i < NUM_RESULTS; i++) begin
         result_nxt[i] = result_r[i];
      end
      if (meas_valid && meas_slot < NUM_RESULTS[1:0]) begin
         result_nxt[meas_slot] = meas_code;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_RESULTS; i++) begin
            result_r[i] <= RESULT_RESET[WORD_W-1:CODE_LSB];
         end
      end else begin
         for (int i = 0; i < NUM_RESULTS; i++) begin
            result_r[i] <= result_nxt[i];
         end
      end
   end

   // ==========================================================
   // nvm control
   nvm_state_type nvm_state_r, nvm_state_nxt;
   logic save_start_r, save_start_nxt;
   logic restore_start_r, restore_start_nxt;
   logic nvm_wr;

   assign nvm_wr = reg_wr && (reg_addr == ADDR_NVM_CTRL);

   // new requests are ignored while one is running; save wins a tie
   always_comb begin
      nvm_state_nxt = nvm_state_r;
      save_start_nxt = 1'b0;
      restore_start_nxt = 1'b0;
      case (nvm_state_r)
         NVM_IDLE: begin
            if (nvm_wr && reg_wdata[SAVE_BIT]) begin
               nvm_state_nxt = NVM_SAVE;
               save_start_nxt = 1'b1;
            end else if (nvm_wr && reg_wdata[RESTORE_BIT]) begin
               nvm_state_nxt = NVM_RESTORE;
               restore_start_nxt = 1'b1;
            end
         end
         NVM_SAVE, NVM_RESTORE: begin
            if (nvm_done) begin
               nvm_state_nxt = NVM_IDLE;
            end
         end
         default: nvm_state_nxt = NVM_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nvm_state_r <= NVM_IDLE;
         save_start_r <= 1'b0;
         restore_start_r <= 1'b0;
      end else begin
         nvm_state_r <= nvm_state_nxt;
         save_start_r <= save_start_nxt;
         restore_start_r <= restore_start_nxt;
      end
   end

   assign save_start = save_start_r;
   assign restore_start = restore_start_r;

   // ==========================================================
   // read path and conversion trigger
   logic [WORD_W-1:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic trig_r, trig_nxt;

   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = reg_rd;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CORR_IN_VOLT: rdata_nxt = pack_code(result_r[SLOT_IN_VOLT]);
            ADDR_CORR_OUT_VOLT:
               rdata_nxt = pack_code(result_r[SLOT_OUT_VOLT]);
            ADDR_CORR_OUT_CURR:
               rdata_nxt = pack_code(result_r[SLOT_OUT_CURR]);
            ADDR_NVM_CTRL: begin
               rdata_nxt = READ_ZERO;
               rdata_nxt[SAVE_BIT] = (nvm_state_r == NVM_SAVE);
               rdata_nxt[RESTORE_BIT] = (nvm_state_r == NVM_RESTORE);
            end
            default: rdata_nxt = READ_ZERO; // unmapped reads zero
         endcase
      end
      trig_nxt = reg_rd && auto_sample
         && (reg_addr == sel_addr(sampling_select));
   end

   // writes to result words fall through with no effect
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= READ_ZERO;
         rvalid_r <= 1'b0;
         trig_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         trig_r <= trig_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign conv_trigger = trig_r;

endmodule

`default_nettype wire

// ==== sim/meas_nvm_bank_checker.sv ====
// assertion checker bound to the measurement and nvm register bank
`timescale 1ns/1ps
`default_nettype none
module meas_nvm_bank_checker
   import meas_nvm_pkg::*;
(
   // watched ports
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [WORD_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic auto_sample,
   input wire logic [1:0] sampling_select,
   input wire logic conv_trigger,
   input wire logic save_start,
   input wire logic restore_start
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // read answers, triggers and start pulses
   sequence s_trig_rd;
      reg_rd && auto_sample && reg_addr == ADDR_CORR_IN_VOLT
         && sampling_select == SEL_IN_VOLT;
   endsequence
   sequence s_res_rd;
      reg_rd && reg_addr != ADDR_NVM_CTRL;
   endsequence
   property p_rv; reg_rd |=> reg_rvalid; endproperty
   property p_norv; !reg_rd |=> !reg_rvalid; endproperty
   property p_low; s_res_rd |=> reg_rdata[3:0] == 4'h0; endproperty
   property p_ctl;
      reg_rd && reg_addr == ADDR_NVM_CTRL |=> reg_rdata[15:2] == 14'h0;
   endproperty
   property p_trig; s_trig_rd |=> conv_trigger; endproperty
   property p_notrig; !reg_rd |=> !conv_trigger; endproperty
   property p_sv; save_start |=> !save_start && !restore_start; endproperty
   property p_rs; restore_start |=> !restore_start && !save_start; endproperty
   a_rv: assert property (p_rv) else $error("read not answered");
   a_norv: assert property (p_norv) else $error("stray answer");
   a_low: assert property (p_low) else $error("low bits set");
   a_ctl: assert property (p_ctl) else $error("ctrl high bits");
   a_trig: assert property (p_trig) else $error("no trigger");
   a_notrig: assert property (p_notrig) else $error("stray trig");
   a_sv: assert property (p_sv) else $error("save pulse long");
   a_rs: assert property (p_rs) else $error("restore pulse");
endmodule
bind meas_nvm_bank meas_nvm_bank_checker u_chk (.clk(clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .auto_sample(auto_sample),
   .sampling_select(sampling_select), .conv_trigger(conv_trigger),
   .save_start(save_start), .restore_start(restore_start));
`default_nettype wire

// ==== sim/nvm_engine_model.sv ====
// behavioural nvm engine answering save and restore starts
`timescale 1ns/1ps
`default_nettype none
module nvm_engine_model #(parameter int BUSY_CYC = 6) (
   // engine handshake
   input wire logic clk,
   input wire logic rstn,
   input wire logic save_start,
   input wire logic restore_start,
   output logic nvm_done
);
   int cnt_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 0;
         nvm_done <= 1'b0;
      end else begin
         nvm_done <= (cnt_r == 1);
         if (save_start || restore_start)
            cnt_r <= BUSY_CYC;
         else if (cnt_r != 0)
            cnt_r <= cnt_r - 1;
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking testbench of the measurement and nvm register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
 $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
   import meas_nvm_pkg::*;
   logic clk, rstn, reg_wr, reg_rd, meas_valid, auto_sample, trig;
   logic save_start, restore_start, nvm_done, reg_rvalid, conv_trigger;
   logic [7:0] reg_addr;
   logic [1:0] meas_slot, sampling_select;
   logic [11:0] meas_code;
   logic [15:0] reg_wdata, reg_rdata, d;
   int mismatches, n_tests;
   localparam logic [11:0] CODES [3] = '{12'h4f5, 12'h1f3, 12'h4b6};
   meas_nvm_bank uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .meas_valid(meas_valid), .meas_slot(meas_slot),
      .meas_code(meas_code), .auto_sample(auto_sample),
      .sampling_select(sampling_select), .conv_trigger(conv_trigger),
      .save_start(save_start), .restore_start(restore_start),
      .nvm_done(nvm_done));
   nvm_engine_model #(.BUSY_CYC(6)) u_nvm (.clk(clk), .rstn(rstn),
      .save_start(save_start), .restore_start(restore_start),
      .nvm_done(nvm_done));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // access tasks, one strobe cycle each
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      d = reg_rdata;
      trig = conv_trigger;
      `CHK(reg_rvalid, 1'b1)
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      #1 reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      test_done;
   end
   // ==========================================================
   // main sequence
   initial begin
      {rstn, reg_wr, reg_rd, meas_valid, auto_sample} = 5'h00;
      {reg_addr, meas_slot, sampling_select} = 12'h000;
      {meas_code, reg_wdata} = 28'h0000000;
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      rd(ADDR_NVM_CTRL);
      `CHK(d, NVM_CTRL_RESET)
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         #1 {meas_valid, meas_slot, meas_code} = {1'b1, 2'(i), CODES[i]};
         @(posedge clk);
         #1 meas_valid = 1'b0;
         wr(8'(ADDR_CORR_IN_VOLT + i), 16'hffff);
         rd(8'(ADDR_CORR_IN_VOLT + i));
         `CHK(d, {CODES[i], 4'h0})
      end
      rd(8'h40);
      `CHK(d, READ_ZERO)
      // host waits for each request to clear; save wins over restore
      for (int i = 1; i < 4; i++) begin
         wr(ADDR_NVM_CTRL, 16'(i));
         `CHK({restore_start, save_start}, 2'(i == 2 ? 2 : 1))
         wr(ADDR_NVM_CTRL, 16'h0003);
         rd(ADDR_NVM_CTRL);
         `CHK(d, 16'(i == 2 ? 2 : 1))
         for (int k = 0; k < 50 && nvm_done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
         end
         `CHK(nvm_done, 1'b1)
         rd(ADDR_NVM_CTRL);
         `CHK(d, NVM_CTRL_RESET)
      end
      // host configures sampling before any triggering read
      auto_sample = 1'b1;
      for (int s = 0; s < 4; s++) begin
         sampling_select = 2'(s);
         rd(8'(ADDR_CORR_IN_VOLT + (s > 1 ? 2 : s)));
         `CHK(trig, s != 2)
      end
      test_done;
   end
endmodule
`default_nettype wire
